/* hdl/pfwc_dev.sv */
// Purpose: Coding-layer end of the fabric word codec.
// Assumes: Fabric end drives reserved positions to zero.
// Notes: Every output is registered; one cycle from link to user side.
// Operation
// - Each octet carries two control, two sideband bits.
// - Sideband 00: K flag, calculated or inverted disparity.
// - Sideband 01: K flag, forced positive or negative.
// - Sideband 10: disparity function bit and K flag.
// - Sideband 11: encoder bypass, ten-bit raw symbol.
// - Receive status 000 to 011, K on control0.
// - Receive status 100 to 111 flag errors.
// - Decoder bypass: raw symbol, sideband codes RXDET, OVF, UNF as 01 to 11, any other status as 00.
// - Wide word: four 40-bit groups, sideband octets.
// - Group bit 36 block start, 39:37 reserved.
// - Second group repeats layout at 40-bit offset.
// - Direct mode: sync header and extra sync header.
// - Codec mode: four K indicators per group.
`timescale 1ns/10ps
`include "pfwc_map.svh"
module pfwc_dev (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Fabric link
	pfwc_if.dev lnk,
	// Configuration
	input wire logic dec_bypass_i,
	input wire logic codec_mode_i,
	// Encoder controls
	output logic [9:0] enc_sym_o,
	output logic enc_k_o,
	output logic enc_disp_o,
	output pfwc_pkg::pfwc_disp_t enc_mode_o,
	output logic enc_valid_o,
	// Decoder results
	input wire logic [9:0] dec_sym_i,
	input wire logic dec_k_i,
	input wire pfwc_pkg::pfwc_st_t dec_st_i,
	input wire logic dec_valid_i,
	// Wide transmit
	output logic [127:0] w_tx_data_o,
	output logic [15:0] w_tx_k_o,
	output logic [7:0] w_tx_sync_o,
	output logic [7:0] w_tx_xsync_o,
	output logic [3:0] w_tx_bs_o,
	output logic [31:0] w_tx_sb_o,
	output logic w_tx_valid_o,
	// Wide receive
	input wire logic [127:0] w_rx_data_i,
	input wire logic [15:0] w_rx_k_i,
	input wire logic [7:0] w_rx_sync_i,
	input wire logic [7:0] w_rx_xsync_i,
	input wire logic [3:0] w_rx_bs_i,
	input wire logic [31:0] w_rx_sb_i,
	input wire logic w_rx_valid_i
);
	logic [9:0] next_enc_sym;
	logic next_enc_k;
	logic next_enc_disp;
	pfwc_pkg::pfwc_disp_t next_enc_mode;
	logic [7:0] next_rx_data;
	logic [1:0] next_rx_ctrl;
	logic [1:0] next_rx_sb;
	logic [127:0] next_w_data;
	logic [15:0] next_w_k;
	logic [7:0] next_w_sync;
	logic [7:0] next_w_xsync;
	logic [3:0] next_w_bs;
	logic [31:0] next_w_sb;
	logic [`PFWC_WIDE_W-1:0] next_rx_wide;
	logic [7:0] rx_data;
	logic [1:0] rx_ctrl;
	logic [1:0] rx_sb;
	logic rx_valid;
	logic [`PFWC_WIDE_W-1:0] rx_wide;
	logic rx_wide_valid;
	wire [127:0] t_data;
	wire [15:0] t_k;
	wire [7:0] t_sync;
	wire [7:0] t_xsync;
	wire [3:0] t_bs;
	wire [31:0] t_sb;
	wire [`PFWC_WIDE_W-1:0] r_word;

	// Transmit octet: side bits select how the encoder treats the data.
	always_comb begin
		next_enc_sym = enc_sym_o;
		next_enc_k = enc_k_o;
		next_enc_disp = enc_disp_o;
		next_enc_mode = enc_mode_o;
		if (lnk.tx_valid) begin
			next_enc_sym = {2'h0, lnk.tx_data};
			next_enc_k = lnk.tx_ctrl[0];
			next_enc_disp = 1'b0;
			case (lnk.tx_sb)
				`PFWC_SB_CALC: begin
					next_enc_mode = lnk.tx_ctrl[1] ? pfwc_pkg::PFWC_INV : pfwc_pkg::PFWC_CALC;
				end
				`PFWC_SB_FORCE: begin
					next_enc_mode = lnk.tx_ctrl[1] ? pfwc_pkg::PFWC_FNEG : pfwc_pkg::PFWC_FPOS;
				end
				`PFWC_SB_FUNC: begin
					next_enc_mode = pfwc_pkg::PFWC_FUNC;
					next_enc_disp = lnk.tx_ctrl[1];
				end
				default: begin
					next_enc_mode = pfwc_pkg::PFWC_RAW;
					next_enc_sym = {lnk.tx_ctrl, lnk.tx_data};
					next_enc_k = 1'b0;
				end
			endcase
		end
	end

	// Receive octet: status code or raw symbol packed into the side bits.
	always_comb begin
		next_rx_data = rx_data;
		next_rx_ctrl = rx_ctrl;
		next_rx_sb = rx_sb;
		if (dec_valid_i) begin
			next_rx_data = dec_sym_i[7:0];
			if (dec_bypass_i) begin
				next_rx_ctrl = dec_sym_i[9:8];
				case (dec_st_i)
					pfwc_pkg::PFWC_ST_RXDET: next_rx_sb = 2'h1;
					pfwc_pkg::PFWC_ST_OVF: next_rx_sb = 2'h2;
					pfwc_pkg::PFWC_ST_UNF: next_rx_sb = 2'h3;
					default: next_rx_sb = 2'h0;
				endcase
			end else begin
				next_rx_ctrl = {dec_st_i[0], dec_k_i};
				next_rx_sb = dec_st_i[2:1];
			end
		end
	end

	genvar g;
	for (g = 0; g < `PFWC_GRPS; g++) begin : grp
		localparam int B = g * `PFWC_GRP_W;
		localparam int S = `PFWC_SB_LSB + g * `PFWC_SB_W;
		assign t_data[g*32 +: 32] = lnk.tx_wide[B +: 32];
		assign t_bs[g] = lnk.tx_wide[B + `PFWC_BS_BIT];
		assign t_k[g*4 +: 4] = codec_mode_i ? lnk.tx_wide[B + `PFWC_K_LSB +: 4] : 4'h0;
		assign t_sync[g*2 +: 2] = codec_mode_i ? 2'h0 : lnk.tx_wide[B + `PFWC_SYNC_LSB +: 2];
		assign t_xsync[g*2 +: 2] = codec_mode_i ? 2'h0 : lnk.tx_wide[B + `PFWC_XSYNC_LSB +: 2];
		assign t_sb[g*8 +: 8] = lnk.tx_wide[S +: `PFWC_SB_W];
		assign r_word[B +: 32] = w_rx_data_i[g*32 +: 32];
		assign r_word[B+32 +: 8] = {3'h0, w_rx_bs_i[g],
			codec_mode_i ? w_rx_k_i[g*4 +: 4] : {w_rx_xsync_i[g*2 +: 2], w_rx_sync_i[g*2 +: 2]}};
		assign r_word[S +: `PFWC_SB_W] = w_rx_sb_i[g*8 +: 8];
	end

	// Wide words hold their last value while no valid word arrives.
	always_comb begin
		next_w_data = w_tx_data_o;
		next_w_k = w_tx_k_o;
		next_w_sync = w_tx_sync_o;
		next_w_xsync = w_tx_xsync_o;
		next_w_bs = w_tx_bs_o;
		next_w_sb = w_tx_sb_o;
		next_rx_wide = rx_wide;
		if (lnk.tx_wide_valid) begin
			next_w_data = t_data;
			next_w_k = t_k;
			next_w_sync = t_sync;
			next_w_xsync = t_xsync;
			next_w_bs = t_bs;
			next_w_sb = t_sb;
		end
		if (w_rx_valid_i) begin
			next_rx_wide = r_word;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			enc_sym_o <= 10'h000;
			enc_k_o <= 1'b0;
			enc_disp_o <= 1'b0;
			enc_mode_o <= pfwc_pkg::PFWC_CALC;
			enc_valid_o <= 1'b0;
			rx_data <= 8'h00;
			rx_ctrl <= 2'h0;
			rx_sb <= 2'h0;
			rx_valid <= 1'b0;
			w_tx_data_o <= '0;
			w_tx_k_o <= 16'h0000;
			w_tx_sync_o <= 8'h00;
			w_tx_xsync_o <= 8'h00;
			w_tx_bs_o <= 4'h0;
			w_tx_sb_o <= 32'h00000000;
			w_tx_valid_o <= 1'b0;
			rx_wide <= '0;
			rx_wide_valid <= 1'b0;
		end else begin
			enc_sym_o <= next_enc_sym;
			enc_k_o <= next_enc_k;
			enc_disp_o <= next_enc_disp;
			enc_mode_o <= next_enc_mode;
			enc_valid_o <= lnk.tx_valid;
			rx_data <= next_rx_data;
			rx_ctrl <= next_rx_ctrl;
			rx_sb <= next_rx_sb;
			rx_valid <= dec_valid_i;
			w_tx_data_o <= next_w_data;
			w_tx_k_o <= next_w_k;
			w_tx_sync_o <= next_w_sync;
			w_tx_xsync_o <= next_w_xsync;
			w_tx_bs_o <= next_w_bs;
			w_tx_sb_o <= next_w_sb;
			w_tx_valid_o <= lnk.tx_wide_valid;
			rx_wide <= next_rx_wide;
			rx_wide_valid <= w_rx_valid_i;
		end
	end

	assign lnk.rx_data = rx_data;
	assign lnk.rx_ctrl = rx_ctrl;
	assign lnk.rx_sb = rx_sb;
	assign lnk.rx_valid = rx_valid;
	assign lnk.rx_wide = rx_wide;
	assign lnk.rx_wide_valid = rx_wide_valid;
endmodule

/* hdl/pfwc_fab.sv */
// Purpose: Fabric end of the fabric word codec, with status registers.
// Assumes: Software sets the mode bits to match the coding layer.
// Notes: Register reads answer one cycle after the strobe.
`timescale 1ns/10ps
`include "pfwc_map.svh"
module pfwc_fab (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Fabric link
	pfwc_if.fab lnk,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic irq_o,
	// Octet user side
	input wire logic [9:0] tx_sym_i,
	input wire logic tx_k_i,
	input wire logic tx_disp_i,
	input wire logic tx_valid_i,
	output logic [9:0] rx_sym_o,
	output logic rx_k_o,
	output pfwc_pkg::pfwc_st_t rx_st_o,
	output logic rx_valid_o,
	// Wide user side
	input wire logic [127:0] w_tx_data_i,
	input wire logic [15:0] w_tx_k_i,
	input wire logic [7:0] w_tx_sync_i,
	input wire logic [7:0] w_tx_xsync_i,
	input wire logic [3:0] w_tx_bs_i,
	input wire logic [31:0] w_tx_sb_i,
	input wire logic w_tx_valid_i,
	output logic [127:0] w_rx_data_o,
	output logic [15:0] w_rx_k_o,
	output logic [7:0] w_rx_sync_o,
	output logic [7:0] w_rx_xsync_o,
	output logic [3:0] w_rx_bs_o,
	output logic [31:0] w_rx_sb_o,
	output logic w_rx_valid_o
);
	logic [3:0] ctrl, next_ctrl;
	logic [6:0] stat, next_stat, mask, next_mask, ev;
	logic [31:0] next_rdata;
	pfwc_pkg::pfwc_st_t st, next_rx_st, last, next_last;
	logic [9:0] next_rx_sym;
	logic next_rx_k;
	logic byp, codec;
	logic [7:0] tx_data, next_tx_data;
	logic [1:0] tx_ctrl, next_tx_ctrl, tx_sb, next_tx_sb;
	logic tx_valid, tx_wide_valid;
	logic [`PFWC_WIDE_W-1:0] tx_wide, next_tx_wide;
	wire [`PFWC_WIDE_W-1:0] t_word;
	wire [127:0] r_data;
	wire [15:0] r_k;
	wire [7:0] r_sync, r_xsync;
	wire [3:0] r_bs;
	wire [31:0] r_sb;

	assign byp = ctrl[`PFWC_CTRL_BYP];
	assign codec = ctrl[`PFWC_CTRL_CODEC];
	assign st = byp ? pfwc_pkg::pfwc_st_t'({lnk.rx_sb, ^lnk.rx_sb})
		: pfwc_pkg::pfwc_st_t'({lnk.rx_sb, lnk.rx_ctrl[1]});
	assign irq_o = |(stat & mask);

	// Octet lane: bypass codes 01, 10, 11 map to status 3, 5, 6 above.
	always_comb begin
		// Link words move only with their valid, so a mode change never tears a held word.
		next_tx_data = tx_data;
		next_tx_ctrl = tx_ctrl;
		next_tx_sb = tx_sb;
		next_tx_wide = w_tx_valid_i ? t_word : tx_wide;
		if (tx_valid_i) begin
			next_tx_data = tx_sym_i[7:0];
			next_tx_ctrl = (ctrl[1:0] == `PFWC_SB_RAW) ? tx_sym_i[9:8] : {tx_disp_i, tx_k_i};
			next_tx_sb = ctrl[1:0];
		end
		next_rx_sym = byp ? {lnk.rx_ctrl, lnk.rx_data} : {2'h0, lnk.rx_data};
		next_rx_k = byp ? 1'b0 : lnk.rx_ctrl[0];
		next_rx_st = st;
		ev = 7'h00;
		if (lnk.rx_valid && st != pfwc_pkg::PFWC_ST_OK) begin
			ev[st - 3'h1] = 1'b1;
		end
	end

	// Sticky status: an event in the clearing cycle stays set.
	always_comb begin
		next_ctrl = ctrl;
		next_mask = mask;
		next_stat = stat | ev;
		next_last = lnk.rx_valid ? st : last;
		next_rdata = 32'h00000000;
		if (wr_i) begin
			if (addr_i == `PFWC_REG_CTRL) begin
				next_ctrl = wdata_i[3:0];
			end else if (addr_i == `PFWC_REG_STAT) begin
				next_stat = (stat & ~wdata_i[6:0]) | ev;
			end else if (addr_i == `PFWC_REG_MASK) begin
				next_mask = wdata_i[6:0];
			end
		end
		if (rd_i) begin
			if (addr_i == `PFWC_REG_CTRL) begin
				next_rdata = {28'h0, ctrl};
			end else if (addr_i == `PFWC_REG_STAT) begin
				next_rdata = {25'h0, stat};
			end else if (addr_i == `PFWC_REG_MASK) begin
				next_rdata = {25'h0, mask};
			end else if (addr_i == `PFWC_REG_LAST) begin
				next_rdata = {29'h0, last};
			end
		end
	end

	genvar g;
	for (g = 0; g < `PFWC_GRPS; g++) begin : grp
		localparam int B = g * `PFWC_GRP_W;
		localparam int S = `PFWC_SB_LSB + g * `PFWC_SB_W;
		assign t_word[B +: 40] = {3'h0, w_tx_bs_i[g],
			codec ? w_tx_k_i[g*4 +: 4] : {w_tx_xsync_i[g*2 +: 2], w_tx_sync_i[g*2 +: 2]},
			w_tx_data_i[g*32 +: 32]};
		assign t_word[S +: `PFWC_SB_W] = w_tx_sb_i[g*8 +: 8];
		assign r_data[g*32 +: 32] = lnk.rx_wide[B +: 32];
		assign r_bs[g] = lnk.rx_wide[B + `PFWC_BS_BIT];
		assign r_k[g*4 +: 4] = codec ? lnk.rx_wide[B + `PFWC_K_LSB +: 4] : 4'h0;
		assign r_sync[g*2 +: 2] = codec ? 2'h0 : lnk.rx_wide[B + `PFWC_SYNC_LSB +: 2];
		assign r_xsync[g*2 +: 2] = codec ? 2'h0 : lnk.rx_wide[B + `PFWC_XSYNC_LSB +: 2];
		assign r_sb[g*8 +: 8] = lnk.rx_wide[S +: `PFWC_SB_W];
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			ctrl <= `PFWC_CTRL_RST;
			stat <= `PFWC_EV_RST;
			mask <= `PFWC_EV_RST;
			last <= pfwc_pkg::PFWC_ST_OK;
			rdata_o <= 32'h00000000;
			tx_data <= 8'h00;
			tx_ctrl <= 2'h0;
			tx_sb <= 2'h0;
			tx_valid <= 1'b0;
			tx_wide <= '0;
			tx_wide_valid <= 1'b0;
			rx_sym_o <= 10'h000;
			rx_k_o <= 1'b0;
			rx_st_o <= pfwc_pkg::PFWC_ST_OK;
			rx_valid_o <= 1'b0;
			{w_rx_data_o, w_rx_k_o, w_rx_sync_o, w_rx_xsync_o, w_rx_bs_o, w_rx_sb_o} <= '0;
			w_rx_valid_o <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			stat <= next_stat;
			mask <= next_mask;
			last <= next_last;
			rdata_o <= next_rdata;
			tx_data <= next_tx_data;
			tx_ctrl <= next_tx_ctrl;
			tx_sb <= next_tx_sb;
			tx_valid <= tx_valid_i;
			tx_wide <= next_tx_wide;
			tx_wide_valid <= w_tx_valid_i;
			rx_sym_o <= next_rx_sym;
			rx_k_o <= next_rx_k;
			rx_st_o <= next_rx_st;
			rx_valid_o <= lnk.rx_valid;
			{w_rx_data_o, w_rx_k_o, w_rx_sync_o, w_rx_xsync_o, w_rx_bs_o, w_rx_sb_o} <=
				{r_data, r_k, r_sync, r_xsync, r_bs, r_sb};
			w_rx_valid_o <= lnk.rx_wide_valid;
		end
	end

	assign lnk.tx_data = tx_data;
	assign lnk.tx_ctrl = tx_ctrl;
	assign lnk.tx_sb = tx_sb;
	assign lnk.tx_valid = tx_valid;
	assign lnk.tx_wide = tx_wide;
	assign lnk.tx_wide_valid = tx_wide_valid;
endmodule

/* hdl/pfwc_if.sv */
// Purpose: Fabric-side word link between user logic and the coding layer.
// Assumes: One clock shared by both ends.
// Notes: Octet lane for 8b/10b, wide word for 64b/66b and 128b/130b.
`timescale 1ns/10ps
`include "pfwc_map.svh"
interface pfwc_if;
	logic [7:0] tx_data;
	logic [1:0] tx_ctrl;
	logic [1:0] tx_sb;
	logic tx_valid;
	logic [7:0] rx_data;
	logic [1:0] rx_ctrl;
	logic [1:0] rx_sb;
	logic rx_valid;
	logic [`PFWC_WIDE_W-1:0] tx_wide;
	logic tx_wide_valid;
	logic [`PFWC_WIDE_W-1:0] rx_wide;
	logic rx_wide_valid;
	modport dev (
		input tx_data, tx_ctrl, tx_sb, tx_valid, tx_wide, tx_wide_valid,
		output rx_data, rx_ctrl, rx_sb, rx_valid, rx_wide, rx_wide_valid
	);
	modport fab (
		output tx_data, tx_ctrl, tx_sb, tx_valid, tx_wide, tx_wide_valid,
		input rx_data, rx_ctrl, rx_sb, rx_valid, rx_wide, rx_wide_valid
	);
endinterface

/* hdl/pfwc_map.svh */
// Purpose: Bit positions, codes and register offsets of the fabric word codec.
// Assumes: Included by bare name from both ends.
// Notes: Definitions only.
`ifndef PFWC_MAP_SVH
`define PFWC_MAP_SVH
`define PFWC_GRPS 4
`define PFWC_GRP_W 40
`define PFWC_WIDE_W 192
`define PFWC_K_LSB 32
`define PFWC_SYNC_LSB 32
`define PFWC_XSYNC_LSB 34
`define PFWC_BS_BIT 36
`define PFWC_SB_LSB 160
`define PFWC_SB_W 8
`define PFWC_SB_CALC 2'h0
`define PFWC_SB_FORCE 2'h1
`define PFWC_SB_FUNC 2'h2
`define PFWC_SB_RAW 2'h3
`define PFWC_REG_CTRL 8'h00
`define PFWC_REG_STAT 8'h04
`define PFWC_REG_MASK 8'h08
`define PFWC_REG_LAST 8'h0c
`define PFWC_CTRL_BYP 3
`define PFWC_CTRL_CODEC 2
`define PFWC_CTRL_RST 4'h0
`define PFWC_EV_RST 7'h00
`endif

/* hdl/pfwc_pkg.sv */
// Purpose: Types shared by both ends of the fabric word codec.
// Assumes: Nothing beyond the map header.
// Notes: Status codes follow the three-bit receive status layout.
package pfwc_pkg;
	typedef enum logic [5:0] {
		PFWC_CALC = 6'h01,
		PFWC_INV = 6'h02,
		PFWC_FPOS = 6'h04,
		PFWC_FNEG = 6'h08,
		PFWC_FUNC = 6'h10,
		PFWC_RAW = 6'h20
	} pfwc_disp_t;
	typedef enum logic [2:0] {
		PFWC_ST_OK = 3'h0,
		PFWC_ST_SKPADD = 3'h1,
		PFWC_ST_SKPRM = 3'h2,
		PFWC_ST_RXDET = 3'h3,
		PFWC_ST_DECERR = 3'h4,
		PFWC_ST_OVF = 3'h5,
		PFWC_ST_UNF = 3'h6,
		PFWC_ST_DISPERR = 3'h7
	} pfwc_st_t;
endpackage

/* testbench/pfwc_checker.sv */
// Purpose: Link-level checks between the two ends of the word codec.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Sees only the interface signals.
`timescale 1ns/10ps
module pfwc_checker (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Octet lane
	input wire logic [7:0] tx_data,
	input wire logic [1:0] tx_ctrl,
	input wire logic [1:0] tx_sb,
	input wire logic tx_valid,
	input wire logic [7:0] rx_data,
	input wire logic [1:0] rx_ctrl,
	input wire logic [1:0] rx_sb,
	input wire logic rx_valid,
	// Wide word
	input wire logic [191:0] tx_wide,
	input wire logic tx_wide_valid,
	input wire logic [191:0] rx_wide,
	input wire logic rx_wide_valid
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);
	// The first cycle after reset is skipped, since its past value is a reset one.
	sequence s_tx_gap;
		$past(nrst_i) && !tx_valid;
	endsequence
	sequence s_rx_gap;
		$past(nrst_i) && !rx_valid;
	endsequence
	AST_TX_HOLD: assert property (s_tx_gap |-> $stable({tx_data, tx_ctrl, tx_sb}))
		else $error("Octet transmit word moved without valid");
	AST_RX_HOLD: assert property (s_rx_gap |-> $stable({rx_data, rx_ctrl, rx_sb}))
		else $error("Octet receive word moved without valid");
	AST_TXW_HOLD: assert property ($past(nrst_i) && !tx_wide_valid |-> $stable(tx_wide))
		else $error("Wide transmit word moved without valid");
	AST_RXW_HOLD: assert property ($past(nrst_i) && !rx_wide_valid |-> $stable(rx_wide))
		else $error("Wide receive word moved without valid");
	AST_TX_RST: assert property (disable iff (1'b0) !nrst_i |=> !tx_valid && !tx_wide_valid)
		else $error("Transmit valid high out of reset");
	AST_RX_RST: assert property (disable iff (1'b0) !nrst_i |=> !rx_valid && !rx_wide_valid)
		else $error("Receive valid high out of reset");
	AST_TXW_RSVD: assert property (tx_wide_valid |-> {tx_wide[159:157], tx_wide[119:117],
		tx_wide[79:77], tx_wide[39:37]} == 12'h000)
		else $error("Reserved transmit bits not zero");
	AST_RXW_RSVD: assert property (rx_wide_valid |-> {rx_wide[159:157], rx_wide[119:117],
		rx_wide[79:77], rx_wide[39:37]} == 12'h000)
		else $error("Reserved receive bits not zero");
endmodule

/* testbench/test_pcs_fabric_word_codec.sv */
// Purpose: Self-checking bench for both ends of the fabric word codec.
// Assumes: Both ends share one clock and reset.
// Notes: Directed stimulus; every wait is bounded.
`timescale 1ns/10ps
module test_pcs_fabric_word_codec;
	logic sys_clk, nrst, wr_s, rd_s, irq;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [9:0] tx_sym, rx_sym, enc_sym, dec_sym;
	logic tx_k, tx_disp, tx_v, rx_k, rx_v, dec_byp, codec, enc_k, enc_disp, enc_v, dec_k, dec_v;
	pfwc_pkg::pfwc_st_t rx_st, dec_st;
	pfwc_pkg::pfwc_disp_t enc_mode;
	logic [127:0] wd, dtd, frd;
	logic [15:0] wk, dtk, frk;
	logic [7:0] ws, wx, dts, dtx, frs, frx;
	logic [3:0] wb, dtb, frb;
	logic [31:0] wsb, dtsb, frsb;
	logic ftv, drv, dtv, frv;
	int n_errors = 0;
	int n_checks = 0;
	wire [3:0] vv = {frv, dtv, rx_v, enc_v};
	pfwc_if i_pfwc_if ();
	wire [191:0] tw = i_pfwc_if.tx_wide;
	pfwc_dev i_pfwc_dev (.sys_clk_i(sys_clk), .nrst_i(nrst), .lnk(i_pfwc_if),
		.dec_bypass_i(dec_byp), .codec_mode_i(codec), .enc_sym_o(enc_sym), .enc_k_o(enc_k),
		.enc_disp_o(enc_disp), .enc_mode_o(enc_mode), .enc_valid_o(enc_v), .dec_sym_i(dec_sym),
		.dec_k_i(dec_k), .dec_st_i(dec_st), .dec_valid_i(dec_v), .w_tx_data_o(dtd),
		.w_tx_k_o(dtk), .w_tx_sync_o(dts), .w_tx_xsync_o(dtx), .w_tx_bs_o(dtb), .w_tx_sb_o(dtsb),
		.w_tx_valid_o(dtv), .w_rx_data_i(wd), .w_rx_k_i(wk), .w_rx_sync_i(ws), .w_rx_xsync_i(wx),
		.w_rx_bs_i(wb), .w_rx_sb_i(wsb), .w_rx_valid_i(drv));
	pfwc_fab i_pfwc_fab (.sys_clk_i(sys_clk), .nrst_i(nrst), .lnk(i_pfwc_if), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .irq_o(irq),
		.tx_sym_i(tx_sym), .tx_k_i(tx_k), .tx_disp_i(tx_disp), .tx_valid_i(tx_v),
		.rx_sym_o(rx_sym), .rx_k_o(rx_k), .rx_st_o(rx_st), .rx_valid_o(rx_v),
		.w_tx_data_i(wd), .w_tx_k_i(wk), .w_tx_sync_i(ws), .w_tx_xsync_i(wx), .w_tx_bs_i(wb),
		.w_tx_sb_i(wsb), .w_tx_valid_i(ftv), .w_rx_data_o(frd), .w_rx_k_o(frk),
		.w_rx_sync_o(frs), .w_rx_xsync_o(frx), .w_rx_bs_o(frb), .w_rx_sb_o(frsb),
		.w_rx_valid_o(frv));
	pfwc_checker i_pfwc_checker (.sys_clk_i(sys_clk), .nrst_i(nrst),
		.tx_data(i_pfwc_if.tx_data), .tx_ctrl(i_pfwc_if.tx_ctrl), .tx_sb(i_pfwc_if.tx_sb),
		.tx_valid(i_pfwc_if.tx_valid), .rx_data(i_pfwc_if.rx_data), .rx_ctrl(i_pfwc_if.rx_ctrl),
		.rx_sb(i_pfwc_if.rx_sb), .rx_valid(i_pfwc_if.rx_valid), .tx_wide(i_pfwc_if.tx_wide),
		.tx_wide_valid(i_pfwc_if.tx_wide_valid), .rx_wide(i_pfwc_if.rx_wide),
		.rx_wide_valid(i_pfwc_if.rx_wide_valid));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic close_out();
		$display("Counts: %0d checks, %0d mismatches", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Waits for one valid pulse and returns just after the edge that shows it.
	task automatic wt(input int s);
		for (int i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			#1;
			if (vv[s] === 1'b1) return;
		end
		n_errors++;
		close_out();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge sys_clk);
		wr_s <= 1'b0;
		// Returning off the edge lets a following write raise the strobe in a later step.
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge sys_clk);
		rd_s <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic rxs(input logic [9:0] s, input logic k, input logic [2:0] st);
		dec_sym <= s;
		dec_k <= k;
		dec_st <= pfwc_pkg::pfwc_st_t'(st);
		dec_v <= 1'b1;
		@(posedge sys_clk);
		dec_v <= 1'b0;
		wt(1);
	endtask
	task automatic t_reg();
		logic [31:0] d;
		chk(enc_mode, pfwc_pkg::PFWC_CALC);
		chk(rx_st, pfwc_pkg::PFWC_ST_OK);
		for (int a = 0; a < 20; a += 4) begin
			rd(a[7:0], d);
			chk(d, 32'h0);
		end
		wr(8'h10, 32'hffff_ffff);
		wr(8'h0c, 32'h7);
		wr(8'h00, 32'hf);
		rd(8'h0c, d);
		chk(d, 32'h0);
		rd(8'h10, d);
		chk(d, 32'h0);
		rd(8'h00, d);
		chk(d, 32'hf);
		$display("t_reg done");
	endtask
	task automatic t_tx();
		logic [5:0] m;
		for (int sb = 0; sb < 4; sb++) begin
			wr(8'h00, sb);
			for (int c = 0; c < 4; c++) begin
				tx_sym <= {c[1:0], 8'hbc};
				{tx_disp, tx_k} <= c[1:0];
				tx_v <= 1'b1;
				@(posedge sys_clk);
				tx_v <= 1'b0;
				wt(0);
				m = sb == 0 ? (c[1] ? pfwc_pkg::PFWC_INV : pfwc_pkg::PFWC_CALC) :
					sb == 1 ? (c[1] ? pfwc_pkg::PFWC_FNEG : pfwc_pkg::PFWC_FPOS) :
					sb == 2 ? pfwc_pkg::PFWC_FUNC : pfwc_pkg::PFWC_RAW;
				chk(enc_mode, m);
				chk(enc_sym, sb == 3 ? {c[1:0], 8'hbc} : 10'h0bc);
				chk(enc_k, sb == 3 ? 1'b0 : c[0]);
				if (sb == 2) chk(enc_disp, c[1]);
				chk({i_pfwc_if.tx_sb, i_pfwc_if.tx_ctrl}, {sb[1:0], c[1:0]});
			end
		end
		$display("t_tx done");
	endtask
	task automatic t_rx();
		logic [31:0] d;
		wr(8'h00, 32'h0);
		for (int s = 0; s < 8; s++) begin
			rxs(10'h37c, s[0], s[2:0]);
			chk(rx_sym, 10'h07c);
			chk(rx_k, s[0]);
			chk(rx_st, s[2:0]);
			chk({i_pfwc_if.rx_sb, i_pfwc_if.rx_ctrl}, {s[2:0], s[0]});
		end
		rd(8'h04, d);
		chk(d, 32'h7f);
		rd(8'h0c, d);
		chk(d, 32'h7);
		chk(irq, 1'b0);
		wr(8'h08, 32'h8);
		rd(8'h08, d);
		chk(d, 32'h8);
		chk(irq, 1'b1);
		wr(8'h04, 32'h7f);
		rd(8'h04, d);
		chk(d, 32'h0);
		chk(irq, 1'b0);
		$display("t_rx done");
	endtask
	task automatic t_byp();
		logic [2:0] st;
		wr(8'h00, 32'h8);
		dec_byp <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			st = i == 0 ? 3'h0 : i == 1 ? 3'h3 : i == 2 ? 3'h5 : 3'h6;
			rxs({i[1:0], 8'h5a}, 1'b1, st);
			chk(rx_sym, {i[1:0], 8'h5a});
			chk({rx_k, rx_st}, {1'b0, st});
			chk({i_pfwc_if.rx_sb, i_pfwc_if.rx_ctrl}, {i[1:0], i[1:0]});
		end
		$display("t_byp done");
	endtask
	task automatic t_wide(input logic c);
		wr(8'h00, {29'h0, c, 2'h0});
		codec <= c;
		{wd, wk, ws, wx, wb, wsb} <= {128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210,
			16'h8421, 8'he4, 8'h1b, 4'ha, 32'h5ac3_96e1};
		ftv <= 1'b1;
		@(posedge sys_clk);
		ftv <= 1'b0;
		wt(2);
		chk(dtd, wd);
		chk({dtk, dts, dtx, dtb, dtsb}, {c ? wk : 16'h0, c ? 16'h0 : {ws, wx}, wb, wsb});
		chk(tw[191:160], wsb);
		chk({tw[76], tw[36]}, wb[1:0]);
		chk(tw[35:32], c ? wk[3:0] : {wx[1:0], ws[1:0]});
		chk(tw[73:72], c ? wk[5:4] : ws[3:2]);
		chk({tw[71:40], tw[31:0]}, wd[63:0]);
		drv <= 1'b1;
		@(posedge sys_clk);
		drv <= 1'b0;
		wt(3);
		chk(frd, wd);
		chk({frk, frs, frx, frb, frsb}, {c ? wk : 16'h0, c ? 16'h0 : {ws, wx}, wb, wsb});
		$display("t_wide done");
	endtask
	initial begin
		nrst = 1'b0;
		{wr_s, rd_s, tx_v, dec_v, ftv, drv, dec_byp, codec, tx_k, tx_disp, dec_k} = '0;
		{addr, wdata, tx_sym, dec_sym} = '0;
		dec_st = pfwc_pkg::PFWC_ST_OK;
		{wd, wk, ws, wx, wb, wsb} = '0;
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		t_reg();
		t_tx();
		t_rx();
		t_byp();
		t_wide(1'b0);
		t_wide(1'b1);
		close_out();
	end
endmodule
